// ==== sim/pgsm_pad_gpio_signal_monitor_test.sv ====
`timescale 1ns/10ps
module pgsm_pad_gpio_signal_monitor_test import pgsm_pkg::*; ();
	logic        clk, rst, psel, pen, pwr, pready, pslverr, iclk, cfe, scan;
	logic        mdrv, moe, fast, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  lvl, drv, oe, ext;
	logic [5:0]  src;
	int          n_mismatch, checks, cyc;

	pgsm_pad_gpio_signal_monitor dut (.CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel),
		.PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
		.PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
		.PIN_LEVEL_IN(lvl), .PIN_DRIVE_OUT(drv), .PIN_OE_OUT(oe),
		.INTERNAL_CLOCK_IN(iclk), .CLOCK_FUNCTION_ENABLE_OUT(cfe),
		.SCAN_ACTIVE_IN(scan), .TX_ENVELOPE_IN(src[0]), .TX_ACTIVE_IN(src[1]),
		.SAM_LINK_SIGNAL_IN(src[2]), .RX_ENVELOPE_IN(src[3]), .RX_ACTIVE_IN(src[4]),
		.RX_BIT_IN(src[5]), .MONITOR_DRIVE_OUT(mdrv), .MONITOR_OE_OUT(moe),
		.FAST_IO_SWITCHING_OUT(fast));
	pgsm_pin_partner pins (.drive_in(drv), .oe_in(oe), .ext_in(ext), .level_out(lvl));

	// ------------------------------------------------------------------
	// Bus and compare helpers
	// ------------------------------------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		// No local limit: the bench's cycle ceiling ends a hung wait
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
		chk(32'(er), 32'h0);
	endtask
	task automatic settle;
		repeat (4) @(posedge clk);
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset;
		rdc(PGSM_ADDR_PIN_OUTPUT_ENABLES, 32'(PGSM_RST_PIN_OUTPUT_ENABLES));
		rdc(PGSM_ADDR_PAD_OUTPUT_VALUES, 32'(PGSM_RST_PAD_OUTPUT_VALUES));
		rdc(PGSM_ADDR_MONITOR_PIN_SELECT, 32'(PGSM_RST_MONITOR_SOURCE));
		chk(32'(moe), 32'h0);
		chk(32'(cfe), 32'h1);
	endtask
	task automatic t_pads;
		iclk <= 1'b1;
		apb(1'b1, PGSM_ADDR_PIN_OUTPUT_ENABLES, 32'h0000_00ff);
		apb(1'b1, PGSM_ADDR_PAD_OUTPUT_VALUES, 32'h0000_00a5);
		settle();
		chk(32'(oe), 32'hff);
		chk(32'(drv), 32'ha5);
		chk(32'(cfe), 32'h0);
		rdc(PGSM_ADDR_PAD_OUTPUT_VALUES, 32'ha5);
		rdc(PGSM_ADDR_PIN_OUTPUT_ENABLES, 32'hff);
		scan <= 1'b1;
		settle();
		chk(32'(oe), 32'hf0);
		chk(32'(drv), 32'ha0);
		rdc(PGSM_ADDR_SCAN_CONTROL, 32'h1);
		rdc(PGSM_ADDR_PIN_OUTPUT_ENABLES, 32'hff);
		scan <= 1'b0;
	endtask
	task automatic t_inputs;
		apb(1'b1, PGSM_ADDR_PIN_OUTPUT_ENABLES, 32'h0000_000f);
		apb(1'b1, PGSM_ADDR_PAD_OUTPUT_VALUES, 32'h0000_0005);
		ext <= 8'h3c;
		settle();
		chk(32'(cfe), 32'h1);
		chk(32'(drv), 32'h45);
		rdc(PGSM_ADDR_PAD_INPUT_LEVELS, 32'h35);
		apb(1'b1, PGSM_ADDR_PAD_INPUT_LEVELS, 32'h0000_00ff);
		chk(32'(er), 32'h0);
		rdc(PGSM_ADDR_PAD_INPUT_LEVELS, 32'h35);
	endtask
	task automatic t_monitor;
		logic [5:0] s;
		logic [3:0] c;
		logic       p;
		for (int pi = 0; pi < 2; pi++) begin
			p = pi[0];
			s = p ? 6'b010101 : 6'b101010;
			src <= s;
			for (int ci = 0; ci < 16; ci++) begin
				c = ci[3:0];
				apb(1'b1, PGSM_ADDR_MONITOR_PIN_SELECT, {24'h0, p, 3'b111, c});
				settle();
				rdc(PGSM_ADDR_MONITOR_PIN_SELECT, {24'h0, p, 3'b000, c});
				chk(32'(fast), 32'(p));
				chk(32'(moe), 32'(ci >= 2 && ci <= 9));
				if (ci >= 2 && ci <= 9) begin
					chk(32'(mdrv), 32'(ci == 3 || (ci >= 4 && s[ci-4])));
				end
			end
		end
	endtask
	task automatic t_unmapped;
		apb(1'b0, 12'h200, 32'h0);
		chk(32'(er), 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, 12'h204, 32'h0000_00ff);
		chk(32'(er), 32'h1);
	endtask

	// ------------------------------------------------------------------
	// Run control
	// ------------------------------------------------------------------
	task automatic final_report;
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always #50 clk = ~clk;
	// The run takes under a thousand cycles, the ceiling leaves wide margin
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			final_report();
		end
	end
	initial begin
		{clk, psel, pen, pwr, iclk, scan} = '0;
		rst = 1'b1;
		paddr = '0;
		pwdata = '0;
		ext = 8'h00;
		src = '0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_pads();
		t_inputs();
		t_monitor();
		t_unmapped();
		final_report();
	end
endmodule // pgsm_pad_gpio_signal_monitor_test

// ==== sim/pgsm_pin_partner.sv ====
`timescale 1ns/10ps
module pgsm_pin_partner
	import pgsm_pkg::*;
(
	input  wire logic [7:0] drive_in,
	input  wire logic [7:0] oe_in,
	input  wire logic [7:0] ext_in,
	output logic      [7:0] level_out
);
	// ------------------------------------------------------------------
	// Pin wires
	// ------------------------------------------------------------------
	// Undriven pins follow the outside circuit, no keeper is assumed
	always_comb begin
		level_out = (oe_in & drive_in) | (~oe_in & ext_in);
	end
endmodule // pgsm_pin_partner

// ==== src/pgsm_pad_gpio_signal_monitor.sv ====
`timescale 1ns/10ps

module pgsm_pad_gpio_signal_monitor
	import pgsm_pkg::*;
(
	input  wire logic        CLK_IN,
	input  wire logic        RESET_IN,
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [11:0] PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	output logic      [31:0] PRDATA_OUT,
	output logic             PREADY_OUT,
	output logic             PSLVERR_OUT,
	input  wire logic [7:0]  PIN_LEVEL_IN,
	output logic      [7:0]  PIN_DRIVE_OUT,
	output logic      [7:0]  PIN_OE_OUT,
	input  wire logic        INTERNAL_CLOCK_IN,
	output logic             CLOCK_FUNCTION_ENABLE_OUT,
	input  wire logic        SCAN_ACTIVE_IN,
	input  wire logic        TX_ENVELOPE_IN,
	input  wire logic        TX_ACTIVE_IN,
	input  wire logic        SAM_LINK_SIGNAL_IN,
	input  wire logic        RX_ENVELOPE_IN,
	input  wire logic        RX_ACTIVE_IN,
	input  wire logic        RX_BIT_IN,
	output logic             MONITOR_DRIVE_OUT,
	output logic             MONITOR_OE_OUT,
	output logic             FAST_IO_SWITCHING_OUT
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  pin_output_enables;
		logic [7:0]  pad_output_values;
		logic        fast_io_switching;
		logic [3:0]  monitor_source_select;
		logic [7:0]  sync_first;
		logic [7:0]  sync_second;
		logic        scan_active;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic [7:0]  pin_drive;
		logic [7:0]  pin_oe;
		logic        clock_function_enable;
		logic        monitor_drive;
		logic        monitor_oe;
	} pgsm_state_type;

	pgsm_state_type state;
	pgsm_state_type next_state;

	// Register read mux, shared by the bus answer
	function automatic logic [31:0] read_word(input logic [11:0] addr,
		input pgsm_state_type s, output logic hit);
		logic [31:0] word;
		word = 32'h0000_0000;
		hit  = 1'b1;
		case (addr)
			PGSM_ADDR_PIN_OUTPUT_ENABLES: word[7:0] = s.pin_output_enables;
			PGSM_ADDR_PAD_OUTPUT_VALUES:  word[7:0] = s.pad_output_values;
			PGSM_ADDR_PAD_INPUT_LEVELS:   word[7:0] = s.sync_second;
			PGSM_ADDR_MONITOR_PIN_SELECT: word[7:0] = {s.fast_io_switching, 3'b000,
				s.monitor_source_select};
			PGSM_ADDR_SCAN_CONTROL:       word[0]   = s.scan_active;
			default:                      hit = 1'b0;
		endcase
		return word;
	endfunction

	// Monitor multiplexer
	function automatic logic [1:0] monitor_mux(input logic [3:0] sel);
		logic [1:0] r; // {oe, drive}
		r = 2'b00;
		case (sel)
			PGSM_SEL_HIZ_A,
			PGSM_SEL_HIZ_B:     r = 2'b00;
			PGSM_SEL_LOW:       r = 2'b10;
			PGSM_SEL_HIGH:      r = 2'b11;
			PGSM_SEL_TX_ENV:    r = {1'b1, TX_ENVELOPE_IN};
			PGSM_SEL_TX_ACTIVE: r = {1'b1, TX_ACTIVE_IN};
			PGSM_SEL_SAM_LINK:  r = {1'b1, SAM_LINK_SIGNAL_IN};
			PGSM_SEL_RX_ENV:    r = {1'b1, RX_ENVELOPE_IN};
			PGSM_SEL_RX_ACTIVE: r = {1'b1, RX_ACTIVE_IN};
			PGSM_SEL_RX_BIT:    r = {1'b1, RX_BIT_IN};
			// Reserved codes leave the pin undriven rather than guess a source
			default:            r = 2'b00;
		endcase
		return r;
	endfunction

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		logic        access;
		logic        hit;
		logic [31:0] word;
		logic [7:0]  eff_oe;
		logic [1:0]  mon;
		access = 1'b0;
		hit    = 1'b0;
		word   = 32'h0000_0000;
		eff_oe = 8'h00;
		mon    = 2'b00;

		next_state = state;

		// Pin levels are not tied to this clock
		next_state.sync_first  = PIN_LEVEL_IN;
		next_state.sync_second = state.sync_first;
		next_state.scan_active = SCAN_ACTIVE_IN;

		// One-wait-state slave: setup, access with pready low, then pready high
		access = PSEL_IN && PENABLE_IN && !state.pready;
		word   = read_word(PADDR_IN, state, hit);
		next_state.pready  = access;
		next_state.pslverr = access && !hit;
		next_state.prdata  = (access && !PWRITE_IN) ? word : 32'h0000_0000;

		if (access && PWRITE_IN) begin
			case (PADDR_IN)
				PGSM_ADDR_PIN_OUTPUT_ENABLES: next_state.pin_output_enables = PWDATA_IN[7:0];
				PGSM_ADDR_PAD_OUTPUT_VALUES:  next_state.pad_output_values = PWDATA_IN[7:0];
				PGSM_ADDR_MONITOR_PIN_SELECT: begin
					next_state.fast_io_switching     = PWDATA_IN[PGSM_BIT_FAST_IO_SWITCHING];
					next_state.monitor_source_select = PWDATA_IN[3:0];
				end
				default: ;
			endcase
		end

		// Scan owns the test pins whatever the enables say
		eff_oe = state.pin_output_enables;
		if (state.scan_active) begin
			eff_oe = eff_oe & ~PGSM_SCAN_PIN_MASK;
		end
		next_state.pin_oe    = eff_oe;
		next_state.pin_drive = state.pad_output_values & eff_oe;
		// Clock pin carries the internal clock unless taken over as output
		next_state.clock_function_enable =
			!state.pin_output_enables[PGSM_BIT_CLOCK_OUTPUT_PIN];
		if (!state.pin_output_enables[PGSM_BIT_CLOCK_OUTPUT_PIN]) begin
			next_state.pin_drive[PGSM_BIT_CLOCK_OUTPUT_PIN] = INTERNAL_CLOCK_IN;
		end

		mon = monitor_mux(state.monitor_source_select);
		next_state.monitor_oe    = mon[1];
		next_state.monitor_drive = mon[0];

		if (RESET_IN) begin
			next_state = '0;
			next_state.pin_output_enables    = PGSM_RST_PIN_OUTPUT_ENABLES;
			next_state.pad_output_values     = PGSM_RST_PAD_OUTPUT_VALUES;
			next_state.monitor_source_select = PGSM_RST_MONITOR_SOURCE;
			next_state.clock_function_enable = 1'b1;
		end
	end

	always_ff @(posedge CLK_IN) begin
		state <= next_state;
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign PRDATA_OUT                = state.prdata;
	assign PREADY_OUT                = state.pready;
	assign PSLVERR_OUT               = state.pslverr;
	assign PIN_DRIVE_OUT             = state.pin_drive;
	assign PIN_OE_OUT                = state.pin_oe;
	assign CLOCK_FUNCTION_ENABLE_OUT = state.clock_function_enable;
	assign MONITOR_DRIVE_OUT         = state.monitor_drive;
	assign MONITOR_OE_OUT            = state.monitor_oe;
	assign FAST_IO_SWITCHING_OUT     = state.fast_io_switching;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	property p_hiz_codes;
		@(posedge CLK_IN) disable iff (RESET_IN)
		(state.monitor_source_select <= 4'h1) |=> !MONITOR_OE_OUT;
	endproperty
	a_hiz_codes: assert property (p_hiz_codes) else $error("monitor driven on hiz code");

	property p_const_levels;
		@(posedge CLK_IN) disable iff (RESET_IN)
		(state.monitor_source_select == 4'h2 || state.monitor_source_select == 4'h3)
		|=> MONITOR_OE_OUT && (MONITOR_DRIVE_OUT == $past(state.monitor_source_select[0]));
	endproperty
	a_const_levels: assert property (p_const_levels) else $error("bad constant level");

	property p_tx_env;
		@(posedge CLK_IN) disable iff (RESET_IN)
		(state.monitor_source_select == 4'h4) |=> (MONITOR_DRIVE_OUT == $past(TX_ENVELOPE_IN));
	endproperty
	a_tx_env: assert property (p_tx_env) else $error("tx envelope not routed");

	property p_sam_link;
		@(posedge CLK_IN) disable iff (RESET_IN)
		(state.monitor_source_select == 4'h6) |=> MONITOR_OE_OUT
			&& (MONITOR_DRIVE_OUT == $past(SAM_LINK_SIGNAL_IN));
	endproperty
	a_sam_link: assert property (p_sam_link) else $error("link signal not routed");

	property p_rx_bit;
		@(posedge CLK_IN) disable iff (RESET_IN)
		(state.monitor_source_select == 4'h9) |=> (MONITOR_DRIVE_OUT == $past(RX_BIT_IN));
	endproperty
	a_rx_bit: assert property (p_rx_bit) else $error("rx bit not routed");

	property p_pin_enable;
		@(posedge CLK_IN) disable iff (RESET_IN)
		##1 ((PIN_OE_OUT & ~$past(state.pin_output_enables)) == 8'h00);
	endproperty
	a_pin_enable: assert property (p_pin_enable) else $error("pin driven without enable");

	property p_clock_off;
		@(posedge CLK_IN) disable iff (RESET_IN)
		state.pin_output_enables[PGSM_BIT_CLOCK_OUTPUT_PIN] |=> !CLOCK_FUNCTION_ENABLE_OUT;
	endproperty
	a_clock_off: assert property (p_clock_off) else $error("clock function left on");

	property p_scan_pins;
		@(posedge CLK_IN) disable iff (RESET_IN)
		state.scan_active |=> (PIN_OE_OUT[3:0] == 4'h0);
	endproperty
	a_scan_pins: assert property (p_scan_pins) else $error("test pin enabled under scan");

	property p_sync_delay;
		@(posedge CLK_IN) disable iff (RESET_IN)
		##2 (state.sync_second == $past(PIN_LEVEL_IN, 2));
	endproperty
	a_sync_delay: assert property (p_sync_delay) else $error("synchroniser depth wrong");

	property p_reserved_zero;
		@(posedge CLK_IN) disable iff (RESET_IN)
		(PSEL_IN && PENABLE_IN && !PREADY_OUT && !PWRITE_IN && PADDR_IN == PGSM_ADDR_MONITOR_PIN_SELECT)
		|=> PREADY_OUT && (PRDATA_OUT[6:4] == 3'b000);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

	property p_tx_active;
		@(posedge CLK_IN) disable iff (RESET_IN)
		(state.monitor_source_select == PGSM_SEL_TX_ACTIVE) |=> MONITOR_OE_OUT
			&& (MONITOR_DRIVE_OUT == $past(TX_ACTIVE_IN));
	endproperty
	a_tx_active: assert property (p_tx_active) else $error("tx active not routed");

	property p_rx_env;
		@(posedge CLK_IN) disable iff (RESET_IN)
		(state.monitor_source_select == PGSM_SEL_RX_ENV) |=> MONITOR_OE_OUT
			&& (MONITOR_DRIVE_OUT == $past(RX_ENVELOPE_IN));
	endproperty
	a_rx_env: assert property (p_rx_env) else $error("rx envelope not routed");

	property p_rx_active;
		@(posedge CLK_IN) disable iff (RESET_IN)
		(state.monitor_source_select == PGSM_SEL_RX_ACTIVE) |=> MONITOR_OE_OUT
			&& (MONITOR_DRIVE_OUT == $past(RX_ACTIVE_IN));
	endproperty
	a_rx_active: assert property (p_rx_active) else $error("rx active not routed");

	// Reserved codes must never drive the pin
	property p_rsvd_codes;
		@(posedge CLK_IN) disable iff (RESET_IN)
		(state.monitor_source_select > PGSM_SEL_RX_BIT) |=> !MONITOR_OE_OUT;
	endproperty
	a_rsvd_codes: assert property (p_rsvd_codes) else $error("reserved code driven");

	// ------------------------------------------------------------------
	// Assertions on register writes and reads, and on pin drive and enables
	// ------------------------------------------------------------------
	property p_fast_write;
		@(posedge CLK_IN) disable iff (RESET_IN)
		(PSEL_IN && PENABLE_IN && !PREADY_OUT && PWRITE_IN
			&& PADDR_IN == PGSM_ADDR_MONITOR_PIN_SELECT)
		|=> (FAST_IO_SWITCHING_OUT == $past(PWDATA_IN[PGSM_BIT_FAST_IO_SWITCHING]));
	endproperty
	a_fast_write: assert property (p_fast_write) else $error("fast bit not stored");

	property p_select_write;
		@(posedge CLK_IN) disable iff (RESET_IN)
		(PSEL_IN && PENABLE_IN && !PREADY_OUT && PWRITE_IN
			&& PADDR_IN == PGSM_ADDR_MONITOR_PIN_SELECT)
		|=> (state.monitor_source_select == $past(PWDATA_IN[3:0]));
	endproperty
	a_select_write: assert property (p_select_write) else $error("select not stored");

	property p_pad_write;
		@(posedge CLK_IN) disable iff (RESET_IN)
		(PSEL_IN && PENABLE_IN && !PREADY_OUT && PWRITE_IN
			&& PADDR_IN == PGSM_ADDR_PAD_OUTPUT_VALUES)
		|=> (state.pad_output_values == $past(PWDATA_IN[7:0]));
	endproperty
	a_pad_write: assert property (p_pad_write) else $error("pad value not stored");

	property p_pad_read;
		@(posedge CLK_IN) disable iff (RESET_IN)
		(PSEL_IN && PENABLE_IN && !PREADY_OUT && !PWRITE_IN
			&& PADDR_IN == PGSM_ADDR_PAD_INPUT_LEVELS)
		|=> PREADY_OUT && (PRDATA_OUT[7:0] == $past(state.sync_second));
	endproperty
	a_pad_read: assert property (p_pad_read) else $error("pad level not returned");

	// Only the clock pin may carry a level while undriven
	property p_drive_masked;
		@(posedge CLK_IN) disable iff (RESET_IN)
		((PIN_DRIVE_OUT & ~PIN_OE_OUT & 8'hbf) == 8'h00);
	endproperty
	a_drive_masked: assert property (p_drive_masked) else $error("drive without enable");

	property p_clock_drive;
		@(posedge CLK_IN) disable iff (RESET_IN)
		!state.pin_output_enables[PGSM_BIT_CLOCK_OUTPUT_PIN] |=> CLOCK_FUNCTION_ENABLE_OUT
			&& (PIN_DRIVE_OUT[PGSM_BIT_CLOCK_OUTPUT_PIN] == $past(INTERNAL_CLOCK_IN));
	endproperty
	a_clock_drive: assert property (p_clock_drive) else $error("clock not carried");

	property p_scan_release;
		@(posedge CLK_IN) disable iff (RESET_IN)
		!state.scan_active |=> (PIN_OE_OUT == $past(state.pin_output_enables));
	endproperty
	a_scan_release: assert property (p_scan_release) else $error("enables not applied");

endmodule // pgsm_pad_gpio_signal_monitor

// ==== src/pgsm_pkg.sv ====
package pgsm_pkg;

	// ------------------------------------------------------------------
	// Register indices and byte addresses
	// ------------------------------------------------------------------
	localparam logic [7:0]  PGSM_IDX_PIN_OUTPUT_ENABLES = 8'h44;
	localparam logic [7:0]  PGSM_IDX_PAD_OUTPUT_VALUES  = 8'h45;
	localparam logic [7:0]  PGSM_IDX_PAD_INPUT_LEVELS   = 8'h46;
	localparam logic [7:0]  PGSM_IDX_MONITOR_PIN_SELECT = 8'h47;
	localparam logic [7:0]  PGSM_IDX_SCAN_CONTROL       = 8'h50;
	localparam logic [11:0] PGSM_ADDR_PIN_OUTPUT_ENABLES = {2'b00, PGSM_IDX_PIN_OUTPUT_ENABLES, 2'b00};
	localparam logic [11:0] PGSM_ADDR_PAD_OUTPUT_VALUES  = {2'b00, PGSM_IDX_PAD_OUTPUT_VALUES, 2'b00};
	localparam logic [11:0] PGSM_ADDR_PAD_INPUT_LEVELS   = {2'b00, PGSM_IDX_PAD_INPUT_LEVELS, 2'b00};
	localparam logic [11:0] PGSM_ADDR_MONITOR_PIN_SELECT = {2'b00, PGSM_IDX_MONITOR_PIN_SELECT, 2'b00};
	localparam logic [11:0] PGSM_ADDR_SCAN_CONTROL       = {2'b00, PGSM_IDX_SCAN_CONTROL, 2'b00};

	// ------------------------------------------------------------------
	// Pin bit positions
	// ------------------------------------------------------------------
	localparam int PGSM_BIT_SIGNAL_INPUT_PIN   = 7;
	localparam int PGSM_BIT_CLOCK_OUTPUT_PIN   = 6;
	localparam int PGSM_BIT_INTERFACE_SELECT_B = 5;
	localparam int PGSM_BIT_INTERFACE_SELECT_A = 4;
	localparam int PGSM_BIT_TEST_CLOCK         = 3;
	localparam int PGSM_BIT_TEST_MODE_SELECT   = 2;
	localparam int PGSM_BIT_TEST_DATA_IN       = 1;
	localparam int PGSM_BIT_TEST_DATA_OUT      = 0;
	localparam logic [7:0] PGSM_SCAN_PIN_MASK  = 8'h0f;

	// ------------------------------------------------------------------
	// Monitor register fields and reset values
	// ------------------------------------------------------------------
	localparam int PGSM_BIT_FAST_IO_SWITCHING  = 7;
	localparam logic [7:0] PGSM_MONITOR_WRITE_MASK = 8'h8f;
	localparam logic [7:0] PGSM_RST_PIN_OUTPUT_ENABLES = 8'h00;
	localparam logic [7:0] PGSM_RST_PAD_OUTPUT_VALUES  = 8'h00;
	localparam logic [3:0] PGSM_RST_MONITOR_SOURCE     = 4'h0;

	typedef enum logic [3:0] {
		PGSM_SEL_HIZ_A     = 4'h0,
		PGSM_SEL_HIZ_B     = 4'h1,
		PGSM_SEL_LOW       = 4'h2,
		PGSM_SEL_HIGH      = 4'h3,
		PGSM_SEL_TX_ENV    = 4'h4,
		PGSM_SEL_TX_ACTIVE = 4'h5,
		PGSM_SEL_SAM_LINK  = 4'h6,
		PGSM_SEL_RX_ENV    = 4'h7,
		PGSM_SEL_RX_ACTIVE = 4'h8,
		PGSM_SEL_RX_BIT    = 4'h9
	} pgsm_source_type;

endpackage
